/* File: rtl/bsdx_addr_form.sv */
// cross-segment virtual address former: base word plus 16-bit u field
// purely combinational, used by the execution unit for b/u addressing
`timescale 1ns/1ps

module bsdx_addr_form
	import bsdx_pkg::*;
(
	input wire logic [35:0] base,
	input wire logic [15:0] u,
	output logic [35:0] target
);

	// ****************************************************
	// address sum
	// ****************************************************
	logic [16:0] sum;

	// carry out lands in the bit below the merged pair
	assign sum = {1'b0, base[15:0]} + {1'b0, u};
	assign target = {base[35:18], base[17] | base[16], sum[16], sum[15:0]};

endmodule

/* File: rtl/bsdx_defs.svh */
// constants for the branch, state and diagnostic execution unit
// assumes doc bit k of a 36-bit word sits at vector bit 35-k
`ifndef BSDX_DEFS_SVH
`define BSDX_DEFS_SVH

// ****************************************************
// operation codes (7-bit f field) and field positions
// ****************************************************
`define BSDX_OPC_DJG 7'h21
`define BSDX_OPC_LAJ 7'h22
`define BSDX_OPC_JXS 7'h23
`define BSDX_OPC_LGM 7'h24
`define BSDX_OPC_SGM 7'h25
`define BSDX_OPC_LOOP_CTRL_SAVE 7'h26
`define BSDX_OPC_LOOP_CTRL_RESTORE 7'h27
`define BSDX_OPC_STK 7'h28
`define BSDX_OPC_GI 7'h29
`define BSDX_OPC_TS 7'h2A
`define BSDX_OPC_TC 7'h2B
`define BSDX_OPC_DGR 7'h2C
`define BSDX_OPC_DGW 7'h2D
`define BSDX_F_HI 35
`define BSDX_F_LO 29
`define BSDX_T_BIT 28
`define BSDX_R1_HI 25
`define BSDX_R1_LO 22
`define BSDX_B_HI 21
`define BSDX_B_LO 18
`define BSDX_G3_HI 15
`define BSDX_G3_LO 12
`define BSDX_U_HI 15
`define BSDX_U_LO 0
`define BSDX_GI_HI 25

// ****************************************************
// storage function codes, stack word, misc
// ****************************************************
`define BSDX_FN_READ 6'h02
`define BSDX_FN_TSET 6'h06
`define BSDX_FN_TCLR 6'h07
`define BSDX_FN_WR1 6'h09
`define BSDX_FN_WR2 6'h0A
`define BSDX_FN_DGW 6'h19
`define BSDX_FN_DGR 6'h1A
`define BSDX_PTR_HI 23
`define BSDX_UB_HI 47
`define BSDX_UB_LO 24
`define BSDX_LB_HI 71
`define BSDX_LB_LO 48
`define BSDX_TS_BIT 66
`define BSDX_TS_PAT 6'h01
`define BSDX_LC_LAST 3'h7
`define BSDX_NREG 16
`define BSDX_NLC 8

`endif

/* File: rtl/bsdx_exec.sv */
// branch, state and diagnostic instruction execution unit
// assumes one instruction offered at a time and a storage unit that answers
// every request once; all inputs are synchronous to mclk
// How it works
// - decrement left word of G(r1); segment-local jump only if result above zero
// - decrement overflow wraps silently, no interrupt, next instruction follows
// - load-address-jump with nonzero b: PAR gets target, G(r1) gets next address
// - no limit check or translation here; target fetch reports faults
// - non-local-jump flag set by external-segment jump and nonzero-b load-address-jump, cleared by every other instruction
// - zero b: displacement ignored, PAR untouched, only next address written
// - external-segment jump stores nothing; zero b takes state register 12
// - multi load/store walks consecutive storage from G(g3) sampled at start
// - register numbers wrap 15 to 0; equal first and last moves one register
// - type clear moves left 36 bits; set moves 72 bits from even address
// - loop-control save and restore move eight double words at even address
// - stack advance increments S7 pointer; above upper bound or overflow interrupts
// - stack advance decodes as opcode followed by 29 zero bits
// - stack retract: opcode, a one, 28 zeros; below lower bound interrupts
// - generate-interrupt raises external interrupt; bits 10-35 passed to software
// - test-and-set sets condition code from bit 5, writes 000001 to bits 0-5
// - test and write indivisible at storage; local segment reference interrupts
// - test-and-clear matches test-and-set but writes zeros to bits 0-5
// - diagnostic read: bad parity answer interrupts, else data loads G(g1)
// - either diagnostic instruction sets diagnose-executed flag
// - diagnostic write drives bad parity on all parity bits unless local
`timescale 1ns/1ps
`include "bsdx_defs.svh"

module bsdx_exec
	import bsdx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic ins_valid,
	input wire logic [35:0] ins_word,
	output logic ins_ready,
	input wire logic [35:0] state12,
	input wire logic [17:0] local_seg,
	input wire logic s7_wr,
	input wire logic [71:0] s7_wdata,
	output logic mem_req_valid,
	input wire logic mem_req_ready,
	output bsdx_mreq_type mem_req,
	input wire logic mem_rsp_valid,
	input wire bsdx_mrsp_type mem_rsp,
	output logic [35:0] par_q,
	output logic [1:0] scc_q,
	output logic nlj_q,
	output logic diag_q,
	output logic [71:0] s7_q,
	output logic int_internal_q,
	output logic int_external_q,
	output logic [25:0] gi_info_q,
	output logic done_q
);

	// ****************************************************
	// helper functions
	// ****************************************************
	function automatic bsdx_op_type decode_op(input logic [35:0] w);
		logic [6:0] f;
		f = w[`BSDX_F_HI:`BSDX_F_LO];
		decode_op = BSDX_OP_OTHER;
		unique case (f)
			`BSDX_OPC_DJG: decode_op = BSDX_OP_DJG;
			`BSDX_OPC_LAJ: decode_op = BSDX_OP_LAJ;
			`BSDX_OPC_JXS: decode_op = BSDX_OP_JXS;
			`BSDX_OPC_LGM: decode_op = BSDX_OP_LGM;
			`BSDX_OPC_SGM: decode_op = BSDX_OP_SGM;
			`BSDX_OPC_LOOP_CTRL_SAVE: decode_op = BSDX_OP_LOOP_CTRL_SAVE;
			`BSDX_OPC_LOOP_CTRL_RESTORE: decode_op = BSDX_OP_LOOP_CTRL_RESTORE;
			`BSDX_OPC_STK: begin
				// trailing bits must be exact, else not a stack op
				if (w[28:0] == 29'h0) decode_op = BSDX_OP_STACK_ADVANCE;
				else if (w[28:0] == 29'h10000000) decode_op = BSDX_OP_STACK_RETRACT;
			end
			`BSDX_OPC_GI: decode_op = BSDX_OP_GI;
			`BSDX_OPC_TS: decode_op = BSDX_OP_TS;
			`BSDX_OPC_TC: decode_op = BSDX_OP_TC;
			`BSDX_OPC_DGR: decode_op = BSDX_OP_DGR;
			`BSDX_OPC_DGW: decode_op = BSDX_OP_DGW;
			default: decode_op = BSDX_OP_OTHER;
		endcase
	endfunction
	// odd parity over a word
	function automatic logic odd_par(input logic [71:0] x);
		odd_par = ~^x;
	endfunction
	function automatic logic is_local(input logic [35:0] a, input logic [17:0] seg);
		is_local = (a[35:18] == seg);
	endfunction

	// ****************************************************
	// state
	// ****************************************************
	logic [71:0] g_q [`BSDX_NREG];
	logic [71:0] lc_q [`BSDX_NLC];
	bsdx_state_type st_q;
	bsdx_op_type op_q;
	logic [3:0] idx_q;
	logic [3:0] last_q;
	logic [3:0] g1_q;
	logic dbl_q;
	logic [35:0] addr_q;

	// ****************************************************
	// decode of the offered instruction
	// ****************************************************
	wire accept = ce && ins_valid && (st_q == BSDX_ST_IDLE);
	wire bsdx_op_type op_w = decode_op(ins_word);
	wire [3:0] r1_w = ins_word[`BSDX_R1_HI:`BSDX_R1_LO];
	wire [3:0] b_w = ins_word[`BSDX_B_HI:`BSDX_B_LO];
	wire [3:0] g3_w = ins_word[`BSDX_G3_HI:`BSDX_G3_LO];
	wire [15:0] u_w = ins_word[`BSDX_U_HI:`BSDX_U_LO];
	wire t_w = ins_word[`BSDX_T_BIT];
	wire b_zero = (b_w == 4'h0);
	wire [35:0] par_next = par_q + 36'h1;
	wire [35:0] local_tgt = {par_q[35:18], 2'b00, u_w};
	wire [35:0] bu_tgt;
	bsdx_addr_form u_addr (
		.base(g_q[b_w][71:36]),
		.u(u_w),
		.target(bu_tgt)
	);
	// decrement wraps in 36 bits; a negative word that wraps positive falls through
	wire [35:0] djg_dec = g_q[r1_w][71:36] - 36'h1;
	wire djg_take = !g_q[r1_w][71] && !djg_dec[35] && (djg_dec != 36'h0);
	// stack pointer arithmetic with field carry and borrow
	wire [24:0] ptr_inc = {1'b0, s7_q[`BSDX_PTR_HI:0]} + 25'h1;
	wire [24:0] ptr_dec = {1'b0, s7_q[`BSDX_PTR_HI:0]} - 25'h1;
	wire stk_up_bad = ptr_inc[24] || (ptr_inc[23:0] > s7_q[`BSDX_UB_HI:`BSDX_UB_LO]);
	wire stk_dn_bad = ptr_dec[24] || (ptr_dec[23:0] < s7_q[`BSDX_LB_HI:`BSDX_LB_LO]);

	// storage start address per operation, taken at issue
	wire multi_w = (op_w == BSDX_OP_LGM) || (op_w == BSDX_OP_SGM);
	wire lcx_w = (op_w == BSDX_OP_LOOP_CTRL_SAVE) || (op_w == BSDX_OP_LOOP_CTRL_RESTORE);
	wire diag_w = (op_w == BSDX_OP_DGR) || (op_w == BSDX_OP_DGW);
	wire tst_w = (op_w == BSDX_OP_TS) || (op_w == BSDX_OP_TC);
	wire [35:0] start_addr = (multi_w || diag_w) ? g_q[g3_w][71:36] : bu_tgt;
	wire start_dbl = (multi_w && t_w) || lcx_w;
	// odd address on a double transfer is refused with an internal interrupt
	wire odd_fault = start_dbl && start_addr[0];
	wire ts_local = tst_w && is_local(start_addr, local_seg);
	wire mem_go = (multi_w || lcx_w || diag_w || tst_w) && !odd_fault && !ts_local;
	wire start_lc = lcx_w;

	// ****************************************************
	// storage request assembly
	// ****************************************************
	wire ldx = (op_q == BSDX_OP_LGM) || (op_q == BSDX_OP_LOOP_CTRL_RESTORE) || (op_q == BSDX_OP_DGR);
	wire dgw_bad = (op_q == BSDX_OP_DGW) && !is_local(addr_q, local_seg);
	logic [5:0] func_w;
	logic [71:0] wdata_w;

	// function code and write data by operation
	always_comb begin
		func_w = `BSDX_FN_READ;
		wdata_w = 72'h0;
		unique case (op_q)
			BSDX_OP_SGM: begin
				func_w = dbl_q ? `BSDX_FN_WR2 : `BSDX_FN_WR1;
				wdata_w = dbl_q ? g_q[idx_q] : {g_q[idx_q][71:36], 36'h0};
			end
			BSDX_OP_LOOP_CTRL_SAVE: begin
				func_w = `BSDX_FN_WR2;
				wdata_w = lc_q[idx_q[2:0]];
			end
			BSDX_OP_TS: begin
				func_w = `BSDX_FN_TSET;
				wdata_w = {`BSDX_TS_PAT, 66'h0};
			end
			BSDX_OP_TC: begin
				func_w = `BSDX_FN_TCLR;
				wdata_w = 72'h0;
			end
			BSDX_OP_DGR: func_w = `BSDX_FN_DGR;
			BSDX_OP_DGW: begin
				func_w = `BSDX_FN_DGW;
				wdata_w = {g_q[g1_q][71:36], 36'h0};
			end
			default: func_w = `BSDX_FN_READ;
		endcase
	end

	// non-local diagnostic write flips every parity bit it sends
	assign mem_req.func = func_w;
	assign mem_req.addr = addr_q;
	assign mem_req.dbl = dbl_q;
	assign mem_req.wdata = wdata_w;
	assign mem_req.apar = odd_par({36'h0, addr_q}) ^ dgw_bad;
	assign mem_req.fpar = odd_par({66'h0, func_w}) ^ dgw_bad;
	assign mem_req.wpar = odd_par(wdata_w) ^ dgw_bad;
	assign mem_req_valid = (st_q == BSDX_ST_REQ);
	assign ins_ready = (st_q == BSDX_ST_IDLE);

	wire rsp_take = ce && (st_q == BSDX_ST_RSP) && mem_rsp_valid;
	wire seq_last = (idx_q == last_q);
	wire seq_more = rsp_take && !seq_last && (op_q != BSDX_OP_DGR) &&
		(op_q != BSDX_OP_DGW) && (op_q != BSDX_OP_TS) && (op_q != BSDX_OP_TC);

	// ****************************************************
	// sequencer
	// ****************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= BSDX_ST_IDLE;
			op_q <= BSDX_OP_OTHER;
			idx_q <= 4'h0;
			last_q <= 4'h0;
			g1_q <= 4'h0;
			dbl_q <= 1'b0;
			addr_q <= 36'h0;
		end else if (ce) begin
			unique case (st_q)
				BSDX_ST_IDLE: if (accept && mem_go) begin
					st_q <= BSDX_ST_REQ;
					op_q <= op_w;
					// start address held, so loading G(g3) cannot move it
					addr_q <= start_addr;
					dbl_q <= start_dbl;
					idx_q <= start_lc ? 4'h0 : (multi_w ? r1_w : 4'h0);
					last_q <= start_lc ? {1'b0, `BSDX_LC_LAST} : (multi_w ? b_w : 4'h0);
					g1_q <= r1_w;
				end
				BSDX_ST_REQ: if (mem_req_ready) st_q <= BSDX_ST_RSP;
				BSDX_ST_RSP: if (mem_rsp_valid) begin
					st_q <= seq_more ? BSDX_ST_REQ : BSDX_ST_IDLE;
					// 4-bit index wraps 15 to 0 by itself
					idx_q <= idx_q + 4'h1;
					addr_q <= addr_q + (dbl_q ? 36'h2 : 36'h1);
				end
				default: st_q <= BSDX_ST_IDLE;
			endcase
		end
	end

	// ****************************************************
	// general registers and loop-control block
	// ****************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < `BSDX_NREG; i++) g_q[i] <= 72'h0;
			for (int i = 0; i < `BSDX_NLC; i++) lc_q[i] <= 72'h0;
		end else if (ce) begin
			if (accept && op_w == BSDX_OP_DJG) begin
				g_q[r1_w][71:36] <= djg_dec;
			end else if (accept && op_w == BSDX_OP_LAJ) begin
				g_q[r1_w][71:36] <= par_next;
			end
			if (rsp_take && ldx) begin
				if (op_q == BSDX_OP_LOOP_CTRL_RESTORE) begin
					lc_q[idx_q[2:0]] <= mem_rsp.rdata;
				end else if (op_q == BSDX_OP_DGR) begin
					if (!mem_rsp.par_err) g_q[g1_q][71:36] <= mem_rsp.rdata[71:36];
				end else if (dbl_q) begin
					g_q[idx_q] <= mem_rsp.rdata;
				end else begin
					g_q[idx_q][71:36] <= mem_rsp.rdata[71:36];
				end
			end
		end
	end

	// ****************************************************
	// program address, flags, stack word
	// ****************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			par_q <= 36'h0;
			nlj_q <= 1'b0;
			diag_q <= 1'b0;
			s7_q <= 72'h0;
		end else if (ce) begin
			if (accept) begin
				// target goes in untranslated; fetch of it reports faults
				unique case (op_w)
					BSDX_OP_DJG: par_q <= djg_take ? local_tgt : par_next;
					BSDX_OP_LAJ: par_q <= b_zero ? par_q : bu_tgt;
					BSDX_OP_JXS: par_q <= b_zero ? state12 : bu_tgt;
					default: par_q <= par_next;
				endcase
				nlj_q <= (op_w == BSDX_OP_LAJ && !b_zero) || (op_w == BSDX_OP_JXS);
				if (diag_w) diag_q <= 1'b1;
			end
			// stack pointer field is written even on a bound fault
			if (accept && op_w == BSDX_OP_STACK_ADVANCE) begin
				s7_q[`BSDX_PTR_HI:0] <= ptr_inc[23:0];
			end else if (accept && op_w == BSDX_OP_STACK_RETRACT) begin
				s7_q[`BSDX_PTR_HI:0] <= ptr_dec[23:0];
			end else if (s7_wr) begin
				s7_q <= s7_wdata;
			end
		end
	end

	// ****************************************************
	// condition code, interrupts, completion
	// ****************************************************
	wire int_in_w = accept && ((op_w == BSDX_OP_STACK_ADVANCE && stk_up_bad) ||
		(op_w == BSDX_OP_STACK_RETRACT && stk_dn_bad) || odd_fault || ts_local);
	wire int_ex_w = (accept && op_w == BSDX_OP_GI) ||
		(rsp_take && op_q == BSDX_OP_DGR && mem_rsp.par_err);

	always_ff @(posedge mclk) begin
		if (rst) begin
			scc_q <= 2'b00;
			int_internal_q <= 1'b0;
			int_external_q <= 1'b0;
			gi_info_q <= 26'h0;
			done_q <= 1'b0;
		end else if (ce) begin
			int_internal_q <= int_in_w;
			int_external_q <= int_ex_w;
			done_q <= (accept && !mem_go) || (rsp_take && !seq_more);
			if (accept && op_w == BSDX_OP_GI) gi_info_q <= ins_word[`BSDX_GI_HI:0];
			// storage performs the tested write atomically
			if (rsp_take && (op_q == BSDX_OP_TS || op_q == BSDX_OP_TC)) begin
				scc_q <= {1'b0, mem_rsp.rdata[`BSDX_TS_BIT]};
			end
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || !ce);

	chk_djg_branch: assert property (accept && op_w == BSDX_OP_DJG && djg_take |=>
		par_q == {$past(par_q[35:18]), 2'b00, $past(u_w)})
		else $error("decrement branch target wrong");
	chk_djg_fall: assert property (accept && op_w == BSDX_OP_DJG && !djg_take |=>
		par_q == $past(par_q) + 36'h1 && !int_internal_q && !int_external_q)
		else $error("decrement fall-through wrong");
	chk_laj_target: assert property (accept && op_w == BSDX_OP_LAJ && !b_zero |=>
		par_q == $past(bu_tgt) && nlj_q)
		else $error("load address jump target wrong");
	chk_nlj_clear: assert property (accept && op_w != BSDX_OP_JXS &&
		!(op_w == BSDX_OP_LAJ && !b_zero) |=> !nlj_q)
		else $error("non-local flag not cleared");
	chk_laj_nojump: assert property (accept && op_w == BSDX_OP_LAJ && b_zero |=>
		par_q == $past(par_q) && g_q[$past(r1_w)][71:36] == $past(par_next))
		else $error("zero base load address wrong");
	chk_jxs_state: assert property (accept && op_w == BSDX_OP_JXS && b_zero |=>
		par_q == $past(state12) && nlj_q)
		else $error("external jump address wrong");
	chk_stack_ovf: assert property (accept && op_w == BSDX_OP_STACK_ADVANCE && stk_up_bad |=>
		int_internal_q)
		else $error("stack advance fault missed");
	chk_ts_local: assert property (accept && ts_local |=>
		int_internal_q && st_q == BSDX_ST_IDLE)
		else $error("local test-and-set not refused");
	chk_dgw_badpar: assert property (mem_req_valid && dgw_bad |->
		mem_req.apar == ^mem_req.addr && mem_req.fpar == ^mem_req.func &&
		mem_req.wpar == ^mem_req.wdata)
		else $error("diagnostic write parity not bad");
	chk_dgr_err: assert property (rsp_take && op_q == BSDX_OP_DGR && mem_rsp.par_err |=>
		int_external_q && st_q == BSDX_ST_IDLE)
		else $error("diagnostic read error not raised");
	chk_diag_flag: assert property (accept && diag_w |=> diag_q)
		else $error("diagnose flag not set");
	cov_multi_wrap: cover property (accept && multi_w && b_w < r1_w);
	cov_ts_done: cover property (rsp_take && op_q == BSDX_OP_TS);
	cov_dgr_err: cover property (rsp_take && op_q == BSDX_OP_DGR && mem_rsp.par_err);

endmodule

/* File: rtl/bsdx_pkg.sv */
// types shared by the execution unit and its address former
// assumes bsdx_defs.svh is on the include path
package bsdx_pkg;

	// ****************************************************
	// decoded operations and sequencer states
	// ****************************************************
	typedef enum logic [3:0] {
		BSDX_OP_DJG, BSDX_OP_LAJ, BSDX_OP_JXS, BSDX_OP_LGM, BSDX_OP_SGM,
		BSDX_OP_LOOP_CTRL_SAVE, BSDX_OP_LOOP_CTRL_RESTORE, BSDX_OP_STACK_ADVANCE, BSDX_OP_STACK_RETRACT, BSDX_OP_GI,
		BSDX_OP_TS, BSDX_OP_TC, BSDX_OP_DGR, BSDX_OP_DGW, BSDX_OP_OTHER
	} bsdx_op_type;

	typedef enum logic [1:0] {BSDX_ST_IDLE, BSDX_ST_REQ, BSDX_ST_RSP} bsdx_state_type;

	// ****************************************************
	// storage request and answer carriers
	// ****************************************************
	typedef struct packed {
		logic [5:0] func;
		logic [35:0] addr;
		logic dbl;
		logic [71:0] wdata;
		logic apar;
		logic fpar;
		logic wpar;
	} bsdx_mreq_type;

	typedef struct packed {
		logic [71:0] rdata;
		logic par_err;
	} bsdx_mrsp_type;

endpackage

/* File: verif/branch_state_diag_exec_test.sv */
// self-checking bench for the branch, state and diagnostic execution unit
// assumes bsdx_pkg, bsdx_exec and bsdx_store_model are compiled before it
`timescale 1ns/1ps
`include "bsdx_defs.svh"

module branch_state_diag_exec_test
	import bsdx_pkg::*;
;
	logic mclk, rst, ce, ins_valid, ins_ready, s7_wr, bad_par, ii, ie;
	logic mem_req_valid, mem_req_ready, mem_rsp_valid, nlj_q, diag_q, done_q;
	logic int_internal_q, int_external_q;
	logic [35:0] ins_word, state12, par_q, p;
	logic [17:0] local_seg;
	logic [71:0] s7_wdata, s7_q;
	logic [2:0] slow;
	logic [1:0] scc_q;
	logic [25:0] gi_info_q;
	logic [15:0] n_req, bad_cnt, n0;
	bsdx_mreq_type mem_req, last_req;
	bsdx_mrsp_type mem_rsp;
	int failures, n_tests;

	// ********
	// design, storage partner and clock
	// ********
	bsdx_exec DUT (
		.mclk(mclk), .rst(rst), .ce(ce), .ins_valid(ins_valid), .ins_word(ins_word),
		.ins_ready(ins_ready), .state12(state12), .local_seg(local_seg), .s7_wr(s7_wr),
		.s7_wdata(s7_wdata), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
		.mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp), .par_q(par_q),
		.scc_q(scc_q), .nlj_q(nlj_q), .diag_q(diag_q), .s7_q(s7_q),
		.int_internal_q(int_internal_q), .int_external_q(int_external_q),
		.gi_info_q(gi_info_q), .done_q(done_q));
	bsdx_store_model sm (
		.mclk(mclk), .rst(rst), .slow(slow), .bad_par(bad_par), .mem_req_valid(mem_req_valid),
		.mem_req_ready(mem_req_ready), .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid),
		.mem_rsp(mem_rsp), .n_req(n_req), .bad_cnt(bad_cnt), .last_req(last_req));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ********
	// access tasks
	// ********
	function automatic logic [35:0] enc(input logic [6:0] f, input logic t, input logic [3:0] a,
		input logic [3:0] b, input logic [15:0] u);
		return {f, t, 2'b00, a, b, 2'b00, u};
	endfunction

	task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	// offer one instruction, then gather interrupt pulses until two cycles after it completes
	task automatic run(input logic [35:0] w);
		int k;
		ii = 1'b0;
		ie = 1'b0;
		k = 0;
		ins_valid = 1'b1;
		ins_word = w;
		while (ins_ready !== 1'b1 && k < 200) begin
			@(posedge mclk);
			#1;
			k++;
		end
		@(posedge mclk);
		#1;
		ins_valid = 1'b0;
		for (int j = 0; j < 3; j++) begin
			while (done_q !== 1'b1 && j == 0 && k < 200) begin
				ii |= int_internal_q;
				ie |= int_external_q;
				@(posedge mclk);
				#1;
				k++;
			end
			ii |= int_internal_q;
			ie |= int_external_q;
			if (j < 2) begin
				@(posedge mclk);
				#1;
			end
		end
		if (k >= 200) begin
			failures++;
			$display("Error at %0t: instruction never completed", $time);
			give_verdict();
		end
	endtask

	// load the stack word (bounds 10 and 20), run one stack op, check pointer and fault
	task automatic stk(input logic [35:0] w, input logic [23:0] ps, input logic [23:0] pe,
		input logic ix);
		s7_wr = 1'b1;
		s7_wdata = {24'h000010, 24'h000020, ps};
		@(posedge mclk);
		#1;
		s7_wr = 1'b0;
		run(w);
		chk({s7_q[23:0], ii}, {pe, ix}, "stack");
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ********
	// scenarios
	// ********
	initial begin
		failures = 0;
		n_tests = 0;
		{rst, ce, ins_valid, s7_wr, bad_par} = 5'b11000;
		ins_word = 36'h0;
		s7_wdata = 72'h0;
		slow = 3'h2;
		local_seg = 18'h3FFFF;
		state12 = 36'h0000ABCDE;
		sm.mem[0] = 36'h000050002;
		sm.mem[1] = 36'h000000010;
		sm.mem[2] = 36'h000000002;
		sm.mem[3] = 36'h800000000;
		for (int i = 32; i < 48; i++) sm.mem[i] = 36'hC00000000 | 36'(i);
		sm.mem[48] = {6'h21, 30'h2AAAAAAA};
		repeat (4) @(posedge mclk);
		#1;
		rst = 1'b0;
		chk({ins_ready, mem_req_valid, par_q}, {2'b10, 36'h0}, "reset");
		// registers 15,0,1,2 from a slow storage; G0 is both address and target
		run(enc(`BSDX_OPC_LGM, 1'b0, 4'hF, 4'h2, 16'h0000));
		chk(n_req, 16'h0004, "load count");
		chk({last_req.func, last_req.addr, last_req.dbl}, {`BSDX_FN_READ, 37'h6}, "load");
		slow = 3'h0;
		run(enc(`BSDX_OPC_SGM, 1'b0, 4'hF, 4'h2, 16'h0000));
		for (int i = 0; i < 4; i++) begin
			chk(sm.mem[16 + i], sm.mem[i], "store");
		end
		$display("test multi done");
		p = par_q;
		run(enc(`BSDX_OPC_DJG, 1'b0, 4'h1, 4'h0, 16'h1234));
		chk(par_q, {p[35:18], 2'b00, 16'h1234}, "decrement jump");
		n0 = n_req;
		run(enc(`BSDX_OPC_LGM, 1'b1, 4'h4, 4'h4, 16'h1000));
		chk({ii, n_req}, {1'b1, n0}, "odd double");
		run(enc(`BSDX_OPC_DJG, 1'b0, 4'h1, 4'h0, 16'h4321));
		chk(par_q[15:0] == 16'h4321, 1'b0, "zero no jump");
		run(enc(`BSDX_OPC_DJG, 1'b0, 4'h2, 4'h0, 16'h0777));
		chk({par_q[15:0] == 16'h0777, ii, ie}, 3'b000, "overflow");
		$display("test decrement done");
		n0 = n_req;
		run(enc(`BSDX_OPC_LAJ, 1'b0, 4'h5, 4'hF, 16'h0010));
		chk({par_q, nlj_q}, {36'h000060012, 1'b1}, "cross jump");
		chk({ii, n_req}, {1'b0, n0}, "no check");
		p = par_q;
		run(enc(`BSDX_OPC_LAJ, 1'b0, 4'h5, 4'h0, 16'hFFFF));
		chk({par_q, nlj_q}, {p, 1'b0}, "zero base");
		run(enc(`BSDX_OPC_JXS, 1'b0, 4'h0, 4'h0, 16'h1111));
		chk({par_q, nlj_q}, {state12, 1'b1}, "state jump");
		run({`BSDX_OPC_GI, 3'b000, 26'h2A5A5A5});
		chk({ie, gi_info_q, nlj_q}, {1'b1, 26'h2A5A5A5, 1'b0}, "gen int");
		$display("test jump done");
		stk({`BSDX_OPC_STK, 29'h0}, 24'h00001F, 24'h000020, 1'b0);
		stk({`BSDX_OPC_STK, 29'h0}, 24'h000020, 24'h000021, 1'b1);
		stk({`BSDX_OPC_STK, 29'h0}, 24'hFFFFFF, 24'h000000, 1'b1);
		stk({`BSDX_OPC_STK, 29'h1}, 24'h000015, 24'h000015, 1'b0);
		stk({`BSDX_OPC_STK, 1'b1, 28'h0}, 24'h000011, 24'h000010, 1'b0);
		stk({`BSDX_OPC_STK, 1'b1, 28'h0}, 24'h000010, 24'h00000F, 1'b1);
		stk({`BSDX_OPC_STK, 1'b1, 28'h0}, 24'h000000, 24'hFFFFFF, 1'b1);
		$display("test stack done");
		run(enc(`BSDX_OPC_TS, 1'b0, 4'h0, 4'h1, 16'h0030));
		chk({scc_q, sm.mem[48]}, {2'b01, 6'h01, 30'h2AAAAAAA}, "test set");
		chk(last_req.func, `BSDX_FN_TSET, "atomic");
		run(enc(`BSDX_OPC_TC, 1'b0, 4'h0, 4'h1, 16'h0030));
		chk({scc_q, sm.mem[48]}, {2'b01, 6'h00, 30'h2AAAAAAA}, "test clear");
		run(enc(`BSDX_OPC_TC, 1'b0, 4'h0, 4'h1, 16'h0030));
		chk(scc_q, 2'b00, "clear seen");
		local_seg = 18'h0;
		n0 = n_req;
		run(enc(`BSDX_OPC_TS, 1'b0, 4'h0, 4'h1, 16'h0030));
		chk({ii, n_req}, {1'b1, n0}, "local set");
		local_seg = 18'h3FFFF;
		$display("test atomic done");
		chk(diag_q, 1'b0, "diag idle");
		run(enc(`BSDX_OPC_DGR, 1'b0, 4'h6, 4'h0, 16'hF000));
		run(enc(`BSDX_OPC_SGM, 1'b0, 4'h6, 4'h6, 16'h0000));
		chk({diag_q, sm.mem[16]}, {1'b1, 36'h2}, "diag read");
		bad_par = 1'b1;
		run(enc(`BSDX_OPC_DGR, 1'b0, 4'h7, 4'h0, 16'h0000));
		chk(ie, 1'b1, "bad read");
		n0 = bad_cnt;
		run(enc(`BSDX_OPC_DGW, 1'b0, 4'hF, 4'h0, 16'h0000));
		chk({bad_cnt, sm.mem[16]}, {n0 + 16'h1, 36'h2}, "diag write");
		chk({last_req.apar, last_req.fpar, last_req.wpar},
			{^last_req.addr, ^last_req.func, ^last_req.wdata}, "bad parity");
		local_seg = 18'h0;
		run(enc(`BSDX_OPC_DGW, 1'b0, 4'hF, 4'h0, 16'h0000));
		chk({bad_cnt, sm.mem[16]}, {n0 + 16'h1, 36'h000050002}, "local write");
		$display("test diag done");
		// block at 32 into the loop registers, then back out at 16
		n0 = n_req;
		run(enc(`BSDX_OPC_LOOP_CTRL_RESTORE, 1'b0, 4'h0, 4'h0, 16'h0010));
		run(enc(`BSDX_OPC_LOOP_CTRL_SAVE, 1'b0, 4'h0, 4'h0, 16'h0000));
		chk({n_req, last_req.func, last_req.dbl}, {n0 + 16'h10, `BSDX_FN_WR2, 1'b1}, "loop count");
		for (int i = 0; i < 16; i++) begin
			chk(sm.mem[16 + i], 36'hC00000000 | 36'(32 + i), "loop block");
		end
		$display("test loop done");
		give_verdict();
	end
endmodule

/* File: verif/bsdx_store_model.sv */
// behavioural shared storage unit facing the execution unit's request port
// assumes bsdx_pkg is compiled first and bsdx_defs.svh is on the include path
`timescale 1ns/1ps
`include "bsdx_defs.svh"

module bsdx_store_model
	import bsdx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] slow,
	input wire logic bad_par,
	input wire logic mem_req_valid,
	output logic mem_req_ready,
	input wire bsdx_mreq_type mem_req,
	output logic mem_rsp_valid,
	output bsdx_mrsp_type mem_rsp,
	output logic [15:0] n_req,
	output logic [15:0] bad_cnt,
	output bsdx_mreq_type last_req
);
	// ********
	// storage array and answer sequencing
	// ********
	logic [35:0] mem [0:63];
	bsdx_mrsp_type rsp_d;
	logic [2:0] hold;
	logic [2:0] dly;
	logic busy;
	logic par_ok;
	logic [5:0] a;
	logic [5:0] fn;

	// small array, low address bits only; odd parity expected on every field
	assign a = mem_req.addr[5:0];
	assign fn = mem_req.func;
	assign par_ok = (mem_req.apar == ~^mem_req.addr) && (mem_req.fpar == ~^fn)
		&& (mem_req.wpar == ~^mem_req.wdata);
	assign mem_req_ready = !busy && hold == 3'h0;

	// one request at a time; slow adds wait cycles before taking and answering
	always @(posedge mclk) begin
		mem_rsp_valid <= 1'b0;
		mem_rsp <= bsdx_mrsp_type'(~mem_rsp); // idle answer lines invert each cycle, showing old data every second cycle
		if (rst) begin
			busy <= 1'b0;
			hold <= slow;
			n_req <= 16'h0000;
			bad_cnt <= 16'h0000;
			mem_rsp <= '0;
		end else if (busy) begin
			if (dly == 3'h0) begin
				mem_rsp_valid <= 1'b1;
				mem_rsp <= rsp_d;
				busy <= 1'b0;
				hold <= slow;
			end else begin
				dly <= dly - 3'h1;
			end
		end else if (mem_req_valid && hold != 3'h0) begin
			hold <= hold - 3'h1;
		end else if (mem_req_valid) begin
			busy <= 1'b1;
			dly <= slow;
			n_req <= n_req + 16'h0001;
			last_req <= mem_req;
			rsp_d.rdata <= {mem[a], mem_req.dbl ? mem[a + 6'h01] : ~mem[a]};
			rsp_d.par_err <= (fn == `BSDX_FN_DGR) && bad_par;
			if (!par_ok) begin
				bad_cnt <= bad_cnt + 16'h0001;
			end else if (fn == `BSDX_FN_WR1 || fn == `BSDX_FN_DGW) begin
				mem[a] <= mem_req.wdata[71:36];
			end else if (fn == `BSDX_FN_WR2) begin
				mem[a] <= mem_req.wdata[71:36];
				mem[a + 6'h01] <= mem_req.wdata[35:0];
			end else if (fn == `BSDX_FN_TSET || fn == `BSDX_FN_TCLR) begin
				// read and rewrite inside one accept, so nothing slips in between
				mem[a][35:30] <= (fn == `BSDX_FN_TSET) ? 6'h01 : 6'h00;
			end
		end
	end
endmodule
